// *** rtl/cdro_top.v ***
// Output current detection, zero current detection and remote output terminals
`default_nettype none
`include "cdro_map.vh"
// Notes on behaviour
// - Over-current level 0..200 percent, default 150
// - Over-current delay 0..10 s, default 0
// - Running, current at/above level past delay
// - Over-current flag held at least 100 ms
// - Zero-current level 0..200 percent, default 5
// - Zero-current time 0..1 s, default 0.5
// - Running, current at/below level past time
// - Zero level of zero disables detection
// - Both flags respond within about 0.1 s
// - Codes 12/112 route over-current flag
// - Codes 13/113 route zero-current flag
// - Codes 96/196 route remote word bit
// - Remote word 0..4095, bit sets terminal level
// - Unassigned terminals ignore remote word bits
// - Selection 0/10: power-on clears remote word
// - Selection 1/11: save at power-off, restore
// - Selection 10/11 keep word through drive reset
// - Remote word writable always, despite protection
module cdro_top #(
  parameter TICK_CYCLES = `CDRO_TICK_MS * `CDRO_CLK_KHZ,
  parameter HOLD_CYCLES = `CDRO_HOLD_MS * `CDRO_CLK_KHZ
) (
  // Clock and power-on reset
  input  wire        REF_CLK,
  input  wire        RST_N,
  // Register port
  input  wire [3:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output wire [15:0] REG_RDATA,
  // Drive state from the control logic
  input  wire        RUN_ACTIVE,
  input  wire [7:0]  CUR_PCT,
  input  wire        WRITE_PROTECT,
  input  wire        DRV_RST,
  // Power supervision pin
  input  wire        POWER_FAIL,
  // Nonvolatile storage
  input  wire        NV_LOAD,
  input  wire [7:0]  NV_LOAD_SEL,
  input  wire [11:0] NV_LOAD_WORD,
  output wire        NV_SAVE,
  output wire [11:0] NV_SAVE_WORD,
  // Output terminals
  input  wire [2:0]  OTHER_FN,
  output wire [2:0]  TERM_OUT,
  output wire        OC_FLAG,
  output wire        ZC_FLAG
);

  // Terminal level for a function code; other codes keep their own function
  function term_fn;
    input [7:0] code;
    input       oc;
    input       zc;
    input       rb;
    input       oth;
    begin
      if (code == `CDRO_FC_OC_P)
        term_fn = oc;
      else if (code == `CDRO_FC_OC_N)
        term_fn = ~oc;
      else if (code == `CDRO_FC_ZC_P)
        term_fn = zc;
      else if (code == `CDRO_FC_ZC_N)
        term_fn = ~zc;
      else if (code == `CDRO_FC_REM_P)
        term_fn = rb;
      else if (code == `CDRO_FC_REM_N)
        term_fn = ~rb;
      else
        term_fn = oth;
    end
  endfunction

  // Setting accepted only within its legal range
  function in_range;
    input [15:0] val;
    input [15:0] max;
    begin
      in_range = (val <= max);
    end
  endfunction

  // Retention selection that survives power loss
  function ret_keeps_pwr;
    input [7:0] sel;
    begin
      ret_keeps_pwr = (sel == `CDRO_RET_KEEP) || (sel == `CDRO_RET_KEEP_H);
    end
  endfunction

  // Saturating tick counter step
  function [6:0] sat_inc;
    input [6:0] v;
    begin
      if (v == `CDRO_CNT_MAX)
        sat_inc = v;
      else
        sat_inc = v + 7'h01;
    end
  endfunction

  // Settings
  reg  [7:0]  oc_lvl_q;
  reg  [6:0]  oc_dly_q;
  reg  [7:0]  zc_lvl_q;
  reg  [6:0]  zc_tim_q;
  reg  [7:0]  ret_sel_q;
  reg  [11:0] rem_q;
  reg  [7:0]  func0_q;
  reg  [7:0]  func1_q;
  reg  [7:0]  func2_q;
  // Detection state
  reg  [21:0] tick_cnt_q;
  reg  [21:0] hold_cnt_q;
  reg  [6:0]  oc_cnt_q;
  reg  [6:0]  zc_cnt_q;
  reg         oc_q;
  reg         zc_q;
  // Power-fail synchroniser and save strobe
  reg         pf_s1_q;
  reg         pf_s2_q;
  reg         pf_s3_q;
  reg         save_q;
  reg  [11:0] save_word_q;
  // Bus and terminal outputs
  reg  [15:0] rdata_q;
  reg  [2:0]  term_q;

  // Counter end points kept at full integer width, then cut to the counter width on purpose
  wire [31:0] tick_last;
  wire [31:0] hold_last;
  wire        tick;
  wire        set_ok;
  wire        oc_cond;
  wire        zc_en;
  wire        zc_cond;
  wire        pf_rise;
  wire [15:0] status;

  // End points of the tick and hold counters; both must fit the 22-bit counters
  assign tick_last = TICK_CYCLES - 1;
  assign hold_last = HOLD_CYCLES - 1;
  // 100 ms tick paces both detectors; slow, but it filters current ripple
  assign tick    = (tick_cnt_q == tick_last[21:0]);
  assign set_ok  = REG_WR && !WRITE_PROTECT;
  assign oc_cond = RUN_ACTIVE && (CUR_PCT >= oc_lvl_q);
  assign zc_en   = (zc_lvl_q != 8'h00);
  assign zc_cond = RUN_ACTIVE && zc_en && (CUR_PCT <= zc_lvl_q);
  // The second and third stages feed the edge detector; the first is never used directly
  assign pf_rise = pf_s2_q && !pf_s3_q;

  // Tick generator
  // Free-running from reset, so the first tick lands TICK_CYCLES-1 cycles after release
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      tick_cnt_q <= 22'h000000;
    else if (tick)
      tick_cnt_q <= 22'h000000;
    else
      tick_cnt_q <= tick_cnt_q + 22'h000001;
  end

  // Settings writes; out-of-range values are refused and the old value kept
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oc_lvl_q  <= `CDRO_RST_OC_LVL;
      oc_dly_q  <= `CDRO_RST_OC_DLY;
      zc_lvl_q  <= `CDRO_RST_ZC_LVL;
      zc_tim_q  <= `CDRO_RST_ZC_TIM;
      ret_sel_q <= `CDRO_RST_RET;
      func0_q   <= `CDRO_RST_FUNC;
      func1_q   <= `CDRO_RST_FUNC;
      func2_q   <= `CDRO_RST_FUNC;
    end else if (NV_LOAD) begin
      // Selection itself is a stored setting restored at power-up
      if (NV_LOAD_SEL == `CDRO_RET_CLR || NV_LOAD_SEL == `CDRO_RET_CLR_H || ret_keeps_pwr(NV_LOAD_SEL))
        ret_sel_q <= NV_LOAD_SEL;
    end else if (set_ok) begin
      if (REG_ADDR == `CDRO_A_OC_LVL) begin
        if (in_range(REG_WDATA, `CDRO_LVL_MAX))
          oc_lvl_q <= REG_WDATA[7:0];
      end else if (REG_ADDR == `CDRO_A_OC_DLY) begin
        if (in_range(REG_WDATA, `CDRO_OC_DLY_MAX))
          oc_dly_q <= REG_WDATA[6:0];
      end else if (REG_ADDR == `CDRO_A_ZC_LVL) begin
        if (in_range(REG_WDATA, `CDRO_LVL_MAX))
          zc_lvl_q <= REG_WDATA[7:0];
      end else if (REG_ADDR == `CDRO_A_ZC_TIM) begin
        if (in_range(REG_WDATA, `CDRO_ZC_TIM_MAX))
          zc_tim_q <= REG_WDATA[6:0];
      end else if (REG_ADDR == `CDRO_A_RET_SEL) begin
        if (REG_WDATA[15:8] == 8'h00 &&
            (REG_WDATA[7:0] == `CDRO_RET_CLR || REG_WDATA[7:0] == `CDRO_RET_CLR_H ||
             ret_keeps_pwr(REG_WDATA[7:0])))
          ret_sel_q <= REG_WDATA[7:0];
      end else if (REG_ADDR == `CDRO_A_FUNC0) begin
        if (REG_WDATA[15:8] == 8'h00)
          func0_q <= REG_WDATA[7:0];
      end else if (REG_ADDR == `CDRO_A_FUNC1) begin
        if (REG_WDATA[15:8] == 8'h00)
          func1_q <= REG_WDATA[7:0];
      end else if (REG_ADDR == `CDRO_A_FUNC2) begin
        if (REG_WDATA[15:8] == 8'h00)
          func2_q <= REG_WDATA[7:0];
      end
    end
  end

  // Remote word: power-on clears, restore and drive reset depend on selection
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      rem_q <= `CDRO_RST_REM;
    else if (NV_LOAD) begin
      if (ret_keeps_pwr(NV_LOAD_SEL))
        rem_q <= NV_LOAD_WORD;
    end else if (DRV_RST) begin
      if (ret_sel_q != `CDRO_RET_CLR_H && ret_sel_q != `CDRO_RET_KEEP_H)
        rem_q <= `CDRO_RST_REM;
    end else if (REG_WR && REG_ADDR == `CDRO_A_REM_WORD) begin
      // Write protection deliberately not applied here
      if (in_range(REG_WDATA, `CDRO_REM_MAX))
        rem_q <= REG_WDATA[11:0];
    end
  end

  // Over-current qualification counts whole ticks at or above the level
  // The count saturates, so a long overload never wraps back below the delay
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      oc_cnt_q <= 7'h00;
    else if (DRV_RST)
      oc_cnt_q <= 7'h00;
    else if (tick) begin
      if (oc_cond)
        oc_cnt_q <= sat_inc(oc_cnt_q);
      else
        oc_cnt_q <= 7'h00;
    end
  end

  // Over-current flag with minimum on time
  // The hold restarts only on a fresh rise, so a long overload never stretches it
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oc_q       <= 1'b0;
      hold_cnt_q <= 22'h000000;
    end else if (DRV_RST) begin
      oc_q       <= 1'b0;
      hold_cnt_q <= 22'h000000;
    end else if (tick && oc_cond && oc_cnt_q >= oc_dly_q) begin
      if (!oc_q)
        hold_cnt_q <= hold_last[21:0];
      else if (hold_cnt_q != 22'h000000)
        hold_cnt_q <= hold_cnt_q - 22'h000001;
      oc_q <= 1'b1;
    end else begin
      if (hold_cnt_q != 22'h000000)
        hold_cnt_q <= hold_cnt_q - 22'h000001;
      else if (tick && !oc_cond)
        oc_q <= 1'b0;
    end
  end

  // Zero-current qualification counts whole ticks at or below the level
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      zc_cnt_q <= 7'h00;
    else if (DRV_RST || !zc_en)
      zc_cnt_q <= 7'h00;
    else if (tick) begin
      if (zc_cond)
        zc_cnt_q <= sat_inc(zc_cnt_q);
      else
        zc_cnt_q <= 7'h00;
    end
  end

  // Zero-current flag; disabling it takes effect at once
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      zc_q <= 1'b0;
    else if (DRV_RST || !zc_en)
      zc_q <= 1'b0;
    else if (tick)
      zc_q <= zc_cond && (zc_cnt_q >= zc_tim_q);
  end

  // Power-fail pin synchroniser
  // The pin is asynchronous; two stages settle it before the edge detector sees it
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pf_s1_q <= 1'b0;
      pf_s2_q <= 1'b0;
      pf_s3_q <= 1'b0;
    end else begin
      pf_s1_q <= POWER_FAIL;
      pf_s2_q <= pf_s1_q;
      pf_s3_q <= pf_s2_q;
    end
  end

  // Save only on power loss, never on a drive reset
  // The word is latched on every power loss; only the pulse depends on the selection
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      save_q      <= 1'b0;
      save_word_q <= `CDRO_RST_REM;
    end else begin
      save_q <= pf_rise && ret_keeps_pwr(ret_sel_q);
      if (pf_rise)
        save_word_q <= rem_q;
    end
  end

  // Terminal drivers, registered so they never glitch on code changes
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      term_q <= 3'h0;
    else begin
      term_q[0] <= term_fn(func0_q, oc_q, zc_q, rem_q[0], OTHER_FN[0]);
      term_q[1] <= term_fn(func1_q, oc_q, zc_q, rem_q[1], OTHER_FN[1]);
      term_q[2] <= term_fn(func2_q, oc_q, zc_q, rem_q[2], OTHER_FN[2]);
    end
  end

  // Status word
  assign status = {9'h000, term_q, 1'b0, RUN_ACTIVE, zc_q, oc_q};

  // Read data valid in the cycle after the strobe only; unmapped reads zero
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N)
      rdata_q <= 16'h0000;
    else if (!REG_RD)
      rdata_q <= 16'h0000;
    else if (REG_ADDR == `CDRO_A_OC_LVL)
      rdata_q <= {8'h00, oc_lvl_q};
    else if (REG_ADDR == `CDRO_A_OC_DLY)
      rdata_q <= {9'h000, oc_dly_q};
    else if (REG_ADDR == `CDRO_A_ZC_LVL)
      rdata_q <= {8'h00, zc_lvl_q};
    else if (REG_ADDR == `CDRO_A_ZC_TIM)
      rdata_q <= {9'h000, zc_tim_q};
    else if (REG_ADDR == `CDRO_A_RET_SEL)
      rdata_q <= {8'h00, ret_sel_q};
    else if (REG_ADDR == `CDRO_A_REM_WORD)
      rdata_q <= {4'h0, rem_q};
    else if (REG_ADDR == `CDRO_A_FUNC0)
      rdata_q <= {8'h00, func0_q};
    else if (REG_ADDR == `CDRO_A_FUNC1)
      rdata_q <= {8'h00, func1_q};
    else if (REG_ADDR == `CDRO_A_FUNC2)
      rdata_q <= {8'h00, func2_q};
    else if (REG_ADDR == `CDRO_A_STATUS)
      rdata_q <= status;
    else
      rdata_q <= 16'h0000;
  end

  assign REG_RDATA    = rdata_q;
  assign NV_SAVE      = save_q;
  assign NV_SAVE_WORD = save_word_q;
  assign TERM_OUT     = term_q;
  assign OC_FLAG      = oc_q;
  assign ZC_FLAG      = zc_q;

endmodule
`default_nettype wire

// *** common/cdro_map.vh ***
// Register map, reset values, function codes and timing constants of the current detect block
`ifndef CDRO_MAP_VH
`define CDRO_MAP_VH
// Register offsets (plain register port, 4-bit address)
`define CDRO_A_OC_LVL   4'h0
`define CDRO_A_OC_DLY   4'h1
`define CDRO_A_ZC_LVL   4'h2
`define CDRO_A_ZC_TIM   4'h3
`define CDRO_A_RET_SEL  4'h4
`define CDRO_A_REM_WORD 4'h5
`define CDRO_A_FUNC0    4'h6
`define CDRO_A_FUNC1    4'h7
`define CDRO_A_FUNC2    4'h8
`define CDRO_A_STATUS   4'h9
// Reset values
`define CDRO_RST_OC_LVL 8'h96
`define CDRO_RST_OC_DLY 7'h00
`define CDRO_RST_ZC_LVL 8'h05
`define CDRO_RST_ZC_TIM 7'h05
`define CDRO_RST_RET    8'h00
`define CDRO_RST_REM    12'h000
`define CDRO_RST_FUNC   8'h00
// Setting limits
`define CDRO_LVL_MAX    16'h00C8
`define CDRO_OC_DLY_MAX 16'h0064
`define CDRO_ZC_TIM_MAX 16'h000A
`define CDRO_REM_MAX    16'h0FFF
// Retention selections
`define CDRO_RET_CLR    8'h00
`define CDRO_RET_KEEP   8'h01
`define CDRO_RET_CLR_H  8'h0A
`define CDRO_RET_KEEP_H 8'h0B
// Terminal function codes
`define CDRO_FC_OC_P    8'h0C
`define CDRO_FC_OC_N    8'h70
`define CDRO_FC_ZC_P    8'h0D
`define CDRO_FC_ZC_N    8'h71
`define CDRO_FC_REM_P   8'h60
`define CDRO_FC_REM_N   8'hC4
// Status bit positions
`define CDRO_ST_OC      0
`define CDRO_ST_ZC      1
`define CDRO_ST_RUN     2
`define CDRO_ST_TERM    4
// Timing
`define CDRO_CLK_KHZ    40000
`define CDRO_TICK_MS    100
`define CDRO_HOLD_MS    100
`define CDRO_CNT_MAX    7'h7F
`endif

// *** tb/cdro_asserts.sv ***
// Pin-level checks of the current detect block
`default_nettype none
`include "cdro_map.vh"
module cdro_asserts #(
  parameter int HOLD_CYCLES = 20
) (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  // Register port and drive state
  input wire logic [3:0]  REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic        RUN_ACTIVE,
  input wire logic        DRV_RST,
  input wire logic        POWER_FAIL,
  // Outputs
  input wire logic        NV_SAVE,
  input wire logic [2:0]  TERM_OUT,
  input wire logic        OC_FLAG,
  input wire logic        ZC_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Cycles the over-current flag has stood; 16 bits outlast any hold we use
  logic [15:0] on_cnt_q;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N) on_cnt_q <= 16'h0000;
    else on_cnt_q <= OC_FLAG ? on_cnt_q + 16'h0001 : 16'h0000;
  rd_idle_zero_a: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  status_read_a: assert property ($past(REG_RD) && $past(REG_ADDR) == `CDRO_A_STATUS |->
    REG_RDATA == {9'h000, $past(TERM_OUT), 1'b0, $past(RUN_ACTIVE), $past(ZC_FLAG), $past(OC_FLAG)})
    else $error("status word wrong");
  oc_run_a: assert property ($rose(OC_FLAG) |-> $past(RUN_ACTIVE)) else $error("over-current while stopped");
  zc_run_a: assert property ($rose(ZC_FLAG) |-> $past(RUN_ACTIVE)) else $error("zero-current while stopped");
  oc_hold_a: assert property ($fell(OC_FLAG) && !$past(DRV_RST) |-> on_cnt_q >= HOLD_CYCLES)
    else $error("over-current flag dropped early");
  drv_clear_a: assert property (DRV_RST |=> !OC_FLAG && !ZC_FLAG) else $error("flags kept on drive reset");
  save_pulse_a: assert property (NV_SAVE |=> !NV_SAVE) else $error("save pulse too long");
  save_cause_a: assert property (NV_SAVE |-> $past(POWER_FAIL, 3)) else $error("save without power fail");
  cover property ($rose(OC_FLAG));
  cover property ($rose(ZC_FLAG));
  cover property (NV_SAVE);
endmodule
`default_nettype wire

// *** tb/cdro_brake.sv ***
// Brake model driven by one output terminal
`default_nettype none
module cdro_brake (
  // Clock and terminal level
  input  wire logic clk,
  input  wire logic cmd,
  // Brake state
  output var logic  closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // A relay coil lags the terminal by a cycle
  always_ff @(posedge clk)
    closed <= cmd;
endmodule
`default_nettype wire

// *** tb/tb_current_detect_remote_output.sv ***
// Self-checking bench of the current detect and remote output block
`default_nettype none
`include "cdro_map.vh"
module tb_current_detect_remote_output;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  localparam int HOLD = 50;
  // Stimulus
  logic        REF_CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic        RUN_ACTIVE = 1'b0, WRITE_PROTECT = 1'b0, DRV_RST = 1'b0, POWER_FAIL = 1'b0, NV_LOAD = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic [7:0]  CUR_PCT = 8'h00, NV_LOAD_SEL = 8'h00;
  logic [11:0] NV_LOAD_WORD = 12'h000;
  logic [2:0]  OTHER_FN = 3'h0;
  // Responses
  wire logic [15:0] REG_RDATA;
  wire logic        NV_SAVE, OC_FLAG, ZC_FLAG, brake_closed;
  wire logic [11:0] NV_SAVE_WORD;
  wire logic [2:0]  TERM_OUT;
  int          n_errors = 0, n_tests = 0, cyc = 0, k;
  logic [15:0] v;
  // Terminal 0 rows: code, remote bit, other bit, expected level (flags off)
  logic [10:0] rows [10] = '{{8'h60, 3'b101}, {8'h60, 3'b010}, {8'hC4, 3'b100}, {8'hC4, 3'b001}, {8'h00, 3'b100},
    {8'h00, 3'b011}, {8'h0C, 3'b110}, {8'h70, 3'b111}, {8'h0D, 3'b110}, {8'h71, 3'b111}};
  logic [15:0] dflt [9] = '{16'h0096, 16'h0000, 16'h0005, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]  rets [4] = '{8'h00, 8'h01, 8'h0A, 8'h0B};
  cdro_top #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD)) dut_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RUN_ACTIVE(RUN_ACTIVE), .CUR_PCT(CUR_PCT),
    .WRITE_PROTECT(WRITE_PROTECT), .DRV_RST(DRV_RST), .POWER_FAIL(POWER_FAIL), .NV_LOAD(NV_LOAD),
    .NV_LOAD_SEL(NV_LOAD_SEL), .NV_LOAD_WORD(NV_LOAD_WORD), .NV_SAVE(NV_SAVE), .NV_SAVE_WORD(NV_SAVE_WORD),
    .OTHER_FN(OTHER_FN), .TERM_OUT(TERM_OUT), .OC_FLAG(OC_FLAG), .ZC_FLAG(ZC_FLAG));
  cdro_brake brake_u (.clk(REF_CLK), .cmd(TERM_OUT[0]), .closed(brake_closed));
  always #12.5 REF_CLK = ~REF_CLK;
  // A hang ends the run as a failure
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge REF_CLK) begin
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
    end
    @(posedge REF_CLK) REG_WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge REF_CLK) begin
      REG_ADDR <= a;
      REG_RD <= 1'b1;
    end
    @(posedge REF_CLK) REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e, nm);
  endtask
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 9; i++)
      rdc(i[3:0], dflt[i], "default");
    rdc(4'hA, 16'h0000, "unmapped");
    foreach (rows[i]) begin
      wr(`CDRO_A_FUNC0, {8'h00, rows[i][10:3]});
      wr(`CDRO_A_REM_WORD, {15'h0000, rows[i][2]});
      @(posedge REF_CLK) OTHER_FN <= {2'b00, rows[i][1]};
      cycles(3);
      chk({15'h0000, TERM_OUT[0]}, {15'h0000, rows[i][0]}, "terminal");
    end
    // Terminals 1 and 2 take remote bits 1 and 2, the second one inverted
    wr(`CDRO_A_FUNC1, 16'h0060);
    wr(`CDRO_A_FUNC2, 16'h00C4);
    wr(`CDRO_A_REM_WORD, 16'h0002);
    cycles(2);
    chk({14'h0000, TERM_OUT[2:1]}, 16'h0003, "terminals 1 2");
    wr(`CDRO_A_FUNC1, 16'h0000);
    wr(`CDRO_A_FUNC2, 16'h0000);
    $display("test defaults and routing done");
    wr(`CDRO_A_OC_LVL, 16'h00C9);
    wr(`CDRO_A_OC_DLY, 16'h0065);
    wr(`CDRO_A_ZC_TIM, 16'h000B);
    wr(`CDRO_A_REM_WORD, 16'h0FFF);
    wr(`CDRO_A_REM_WORD, 16'h1000);
    rdc(`CDRO_A_OC_LVL, 16'h0096, "level over");
    rdc(`CDRO_A_OC_DLY, 16'h0000, "delay over");
    rdc(`CDRO_A_ZC_TIM, 16'h0005, "time over");
    rdc(`CDRO_A_REM_WORD, 16'h0FFF, "remote max");
    @(posedge REF_CLK) WRITE_PROTECT <= 1'b1;
    wr(`CDRO_A_OC_LVL, 16'h00C8);
    wr(`CDRO_A_REM_WORD, 16'h0003);
    rdc(`CDRO_A_OC_LVL, 16'h0096, "protected level");
    rdc(`CDRO_A_REM_WORD, 16'h0003, "protected remote");
    @(posedge REF_CLK) WRITE_PROTECT <= 1'b0;
    $display("test limits done");
    // Current exactly at the level, two-tick delay
    wr(`CDRO_A_FUNC0, 16'h000C);
    wr(`CDRO_A_OC_DLY, 16'h0002);
    @(posedge REF_CLK) begin
      RUN_ACTIVE <= 1'b1;
      CUR_PCT <= 8'h96;
    end
    cycles(TICK + 1);
    chk({15'h0000, OC_FLAG}, 16'h0000, "oc early");
    for (k = 0; OC_FLAG !== 1'b1 && k < 3 * TICK; k++) cycles(1);
    chk({15'h0000, OC_FLAG}, 16'h0001, "oc set");
    rdc(`CDRO_A_STATUS, 16'h0015, "status");
    @(posedge REF_CLK) CUR_PCT <= 8'h64;
    cycles(HOLD - 8);
    chk({15'h0000, OC_FLAG}, 16'h0001, "oc hold");
    for (k = 0; OC_FLAG !== 1'b0 && k < HOLD + 2 * TICK; k++) cycles(1);
    chk({15'h0000, OC_FLAG}, 16'h0000, "oc clear");
    // Zero current at the level boundary
    wr(`CDRO_A_FUNC0, 16'h000D);
    @(posedge REF_CLK) CUR_PCT <= 8'h05;
    cycles(4 * TICK);
    chk({15'h0000, ZC_FLAG}, 16'h0000, "zc early");
    for (k = 0; ZC_FLAG !== 1'b1 && k < 4 * TICK; k++) cycles(1);
    cycles(2);
    chk({14'h0000, brake_closed, ZC_FLAG}, 16'h0003, "zc set");
    wr(`CDRO_A_ZC_LVL, 16'h0000);
    cycles(2);
    chk({15'h0000, ZC_FLAG}, 16'h0000, "zc off");
    @(posedge REF_CLK) RUN_ACTIVE <= 1'b0;
    $display("test detection done");
    // Every retention mode through a drive reset and a power fail
    foreach (rets[i]) begin
      wr(`CDRO_A_RET_SEL, {8'h00, rets[i]});
      wr(`CDRO_A_REM_WORD, 16'h0005);
      @(posedge REF_CLK) DRV_RST <= 1'b1;
      @(posedge REF_CLK) DRV_RST <= 1'b0;
      rdc(`CDRO_A_REM_WORD, rets[i][3] ? 16'h0005 : 16'h0000, "drive reset");
      wr(`CDRO_A_REM_WORD, 16'h0006);
      @(posedge REF_CLK) POWER_FAIL <= 1'b1;
      k = 0;
      v = 16'h0000;
      repeat (8) begin
        cycles(1);
        if (NV_SAVE === 1'b1) begin
          k++;
          v = {4'h0, NV_SAVE_WORD};
        end
      end
      @(posedge REF_CLK) POWER_FAIL <= 1'b0;
      chk(k[15:0], {15'h0000, rets[i][0]}, "saves");
      chk(v, rets[i][0] ? 16'h0006 : 16'h0000, "saved word");
    end
    // Power-on reset clears the word, a restore brings it back
    @(posedge REF_CLK) RST_N <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rdc(`CDRO_A_REM_WORD, 16'h0000, "power-on");
    @(posedge REF_CLK) begin
      NV_LOAD <= 1'b1;
      NV_LOAD_SEL <= 8'h01;
      NV_LOAD_WORD <= 12'h006;
    end
    @(posedge REF_CLK) NV_LOAD <= 1'b0;
    rdc(`CDRO_A_REM_WORD, 16'h0006, "restored");
    rdc(`CDRO_A_RET_SEL, 16'h0001, "restored sel");
    $display("test retention done");
    conclude();
  end
endmodule
bind cdro_top cdro_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .RUN_ACTIVE(RUN_ACTIVE), .DRV_RST(DRV_RST), .POWER_FAIL(POWER_FAIL), .NV_SAVE(NV_SAVE),
  .TERM_OUT(TERM_OUT), .OC_FLAG(OC_FLAG), .ZC_FLAG(ZC_FLAG));
`default_nettype wire
